// ==== logic/spio_port.sv ====
`timescale 1ns/1ps
// Overview of operation
// - An actively driving enabled peripheral wins the pin over the port bit.
// - Two muxes per pin choose peripheral or port for data and enable.
// - Port output is not fed back into the sharing peripheral's input while the port drives the pin.
// - Peripheral driving disables port driver; pin reads still show the pin.
// - Enabled but idle peripheral lets the port drive per direction and latch.
// - Direction bit 1 makes the pin input, 0 makes it output.
// - Every reset makes all port pins inputs.
// - Latch reads return the latch; latch writes update it.
// - Pin-value reads return pin levels; writes there update the latch.
// - Unimplemented bits are disabled and read zero in all three views.
// - Pins shared only with input functions act as dedicated port pins.
// - Six virtual pins fed by remapper outputs 176 to 181, no package pin.
// - Any input remapper may select any of the six virtual pins.
// - Fault 1 select value 1 routes comparator 1 output to fault 1.
module spio_port
    import spio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic direction_wr_en,
    input wire logic [15:0] direction_wr_data,
    input wire logic output_latch_wr_en,
    input wire logic [15:0] output_latch_wr_data,
    input wire logic pin_value_wr_en,
    input wire logic [15:0] pin_value_wr_data,
    output logic [15:0] direction_rd,
    output logic [15:0] output_latch_rd,
    output logic [15:0] pin_value_rd,
    input wire logic [15:0] periph_enable,
    input wire logic [15:0] periph_drive,
    input wire logic [15:0] periph_out,
    output logic [15:0] periph_in,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe_n,
    input wire logic [5:0] virtual_remap_outputs,
    output logic [5:0] virtual_pins,
    input wire logic comparator1_output,
    input wire logic [7:0] fault1_input_select,
    input wire logic [23:0] remap_select,
    output logic fault1_input,
    output logic [2:0] remap_in
);

    // ==========================================================
    // Pin synchronisers
    // Two stages per pin: pin reads and peripheral inputs lag the pad by three edges
    logic [15:0] pin_sync;

    genvar gi;
    generate
        for (gi = 0; gi < PIO_W; gi++)
        begin : g_pin
            spio_sync2 u_sync (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .d(pin_in[gi]),
                .q(pin_sync[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Port state
    spio_state_t st_ff;
    spio_state_t nxt_st;
    logic [15:0] own_now;
    logic [15:0] port_drv;

    // Input-only shared pins have no competing driver, so peripheral drive is ignored
    assign own_now = periph_enable & periph_drive & PIO_IMPL_MASK & ~PIO_INPUT_ONLY_MASK;
    // Bits on which the port itself is putting a level on the pad
    assign port_drv = ~st_ff.pin_oe_n & ~st_ff.owned;

    always_comb
    begin
        nxt_st = st_ff;
        if (direction_wr_en)
        begin
            nxt_st.dir = direction_wr_data;
        end
        // A direct latch write beats a pin-value write in the same cycle
        if (output_latch_wr_en)
        begin
            nxt_st.latch = output_latch_wr_data;
        end
        else if (pin_value_wr_en)
        begin
            nxt_st.latch = pin_value_wr_data;
        end
        // Unimplemented bits are held as inputs with a zero latch
        nxt_st.dir = nxt_st.dir | ~PIO_IMPL_MASK;
        nxt_st.latch = nxt_st.latch & PIO_IMPL_MASK;
        nxt_st.owned = own_now;
        nxt_st.pin_out = (own_now & periph_out) | (~own_now & nxt_st.latch);
        nxt_st.pin_oe_n = ~own_now & nxt_st.dir;
        nxt_st.dir_rd = nxt_st.dir & PIO_IMPL_MASK;
        nxt_st.latch_rd = nxt_st.latch;
        nxt_st.pin_rd = pin_sync & PIO_IMPL_MASK;
        nxt_st.periph_in = pin_sync & ~port_drv & PIO_IMPL_MASK;
        nxt_st.virt = virtual_remap_outputs;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff.dir <= PIO_DIR_RESET;
            st_ff.latch <= PIO_LATCH_RESET;
            st_ff.owned <= PIO_ZERO;
            st_ff.pin_out <= PIO_ZERO;
            st_ff.pin_oe_n <= PIO_OE_N_RESET;
            st_ff.dir_rd <= PIO_IMPL_MASK;
            st_ff.latch_rd <= PIO_LATCH_RESET;
            st_ff.pin_rd <= PIO_ZERO;
            st_ff.periph_in <= PIO_ZERO;
            st_ff.virt <= VIRT_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign direction_rd = st_ff.dir_rd;
    assign output_latch_rd = st_ff.latch_rd;
    assign pin_value_rd = st_ff.pin_rd;
    assign pin_out = st_ff.pin_out;
    assign pin_oe_n = st_ff.pin_oe_n;
    assign periph_in = st_ff.periph_in;
    assign virtual_pins = st_ff.virt;

    // ==========================================================
    // Input remappers, slot 0 feeds the fault 1 input
    logic [31:0] all_sel;
    logic [3:0] all_remap;

    assign all_sel = {remap_select, fault1_input_select};

    generate
        for (gi = 0; gi < IN_REMAP_N; gi++)
        begin : g_remap
            spio_in_remap u_remap (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .sel(all_sel[gi*REMAP_SEL_W +: REMAP_SEL_W]),
                .comparator1_output(comparator1_output),
                .pin_src(st_ff.periph_in),
                .virt_src(st_ff.virt),
                .remap_out(all_remap[gi])
            );
        end
    endgenerate

    assign fault1_input = all_remap[0];
    assign remap_in = all_remap[3:1];

    // Slot checks sit at this level so a crossed select or source wire shows up
    generate
        for (gi = 0; gi < IN_REMAP_N; gi++)
        begin : g_slot_chk
            logic [7:0] slot_sel;

            assign slot_sel = all_sel[gi*REMAP_SEL_W +: REMAP_SEL_W];

            a_slot_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
                (slot_sel == REMAP_SEL_ZERO) |=> !all_remap[gi])
                else $error("zero select did not hold the remapper output low");

            a_slot_cmp: assert property (@(posedge clk_sys) disable iff (!rst_n)
                (slot_sel == REMAP_SEL_CMP1) |=> (all_remap[gi] == $past(comparator1_output)))
                else $error("comparator select did not reach its slot");

            a_slot_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
                (slot_sel >= REMAP_SEL_PIN_BASE && slot_sel <= REMAP_SEL_PIN_LAST)
                |=> (all_remap[gi] == $past(periph_in[slot_sel[3:0]])))
                else $error("pin select did not return the guarded pin input");

            a_slot_virt: assert property (@(posedge clk_sys) disable iff (!rst_n)
                (slot_sel >= REMAP_SEL_VIRT_BASE && slot_sel <= REMAP_SEL_VIRT_LAST)
                |=> (all_remap[gi] == $past(virtual_pins[slot_sel[2:0]])))
                else $error("virtual select did not return its virtual pin");
        end
    endgenerate

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_periph_owns_pin: assert property (
        1'b1 |=> (((pin_out ^ $past(periph_out)) | pin_oe_n) & $past(own_now)) == PIO_ZERO)
        else $error("driving peripheral did not own the pin");

    a_mux_port_path: assert property (
        1'b1 |=> ((pin_out ^ output_latch_rd) & ~$past(own_now)) == PIO_ZERO)
        else $error("port data mux does not show the latch");

    a_no_loop_through: assert property (
        1'b1 |=> (periph_in & $past(port_drv)) == PIO_ZERO)
        else $error("port output looped into a peripheral input");

    // All three past edges must be out of reset, or a reset in mid-run trips it
    a_pin_read_kept: assert property (
        ($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3))
        |-> (pin_value_rd == ($past(pin_in, 3) & PIO_IMPL_MASK)))
        else $error("pin read does not follow the pad three cycles later");

    a_port_enable_mux: assert property (
        1'b1 |=> (((pin_oe_n ^ direction_rd) & PIO_IMPL_MASK) & ~$past(own_now)) == PIO_ZERO)
        else $error("idle peripheral pin does not follow direction");

    a_dir_write_input: assert property (
        (direction_wr_en && !output_latch_wr_en)
        |=> ((pin_oe_n & PIO_IMPL_MASK) == ($past(direction_wr_data & ~own_now) & PIO_IMPL_MASK)))
        else $error("direction write gave wrong pin enable");

    a_reset_inputs: assert property (
        !$past(rst_n) |-> (direction_rd == PIO_IMPL_MASK && pin_oe_n == PIO_OE_N_RESET))
        else $error("pins are not inputs after reset");

    a_latch_write: assert property (
        output_latch_wr_en |=> output_latch_rd == ($past(output_latch_wr_data) & PIO_IMPL_MASK))
        else $error("latch write not reflected in latch read");

    a_pin_write_latch: assert property (
        (pin_value_wr_en && !output_latch_wr_en)
        |=> output_latch_rd == ($past(pin_value_wr_data) & PIO_IMPL_MASK))
        else $error("pin value write did not update the latch");

    a_unimpl_zero: assert property (
        ((direction_rd | output_latch_rd | pin_value_rd | periph_in) & ~PIO_IMPL_MASK) == PIO_ZERO
        && (pin_oe_n & ~PIO_IMPL_MASK) == ~PIO_IMPL_MASK)
        else $error("unimplemented bit is not disabled");

    a_input_only_port: assert property (
        1'b1 |=> (pin_oe_n & PIO_INPUT_ONLY_MASK) == (direction_rd & PIO_INPUT_ONLY_MASK))
        else $error("input-only shared pin was taken by a peripheral");

    a_virtual_pins: assert property (
        1'b1 |=> virtual_pins == $past(virtual_remap_outputs))
        else $error("virtual pin does not follow its remapper output");

    // ==========================================================
    // Checks: register views, idle pins and reset values

    a_dir_write_rd: assert property (
        direction_wr_en |=> direction_rd == ($past(direction_wr_data) & PIO_IMPL_MASK))
        else $error("direction write not reflected in direction read");

    a_dir_hold: assert property (
        !direction_wr_en |=> $stable(direction_rd))
        else $error("direction changed without a write");

    a_latch_hold: assert property (
        (!output_latch_wr_en && !pin_value_wr_en) |=> $stable(output_latch_rd))
        else $error("latch changed without a write");

    // Undriven pins must still reach peripherals, not only be blocked where driven
    a_loop_pass: assert property (
        1'b1 |=> ((periph_in ^ pin_value_rd) & ~$past(port_drv)) == PIO_ZERO)
        else $error("undriven pin did not reach the peripheral input");

    a_input_only_latch: assert property (
        1'b1 |=> ((pin_out ^ output_latch_rd) & PIO_INPUT_ONLY_MASK) == PIO_ZERO)
        else $error("input-only shared pin does not carry the latch");

    a_drive_only_enabled: assert property (
        1'b1 |=> ((pin_out ^ output_latch_rd) & ~$past(periph_enable)) == PIO_ZERO)
        else $error("disabled peripheral took the pin data");

    a_idle_periph_off: assert property (
        1'b1 |=> ((pin_oe_n ^ direction_rd) & ~$past(periph_drive) & PIO_IMPL_MASK) == PIO_ZERO)
        else $error("idle peripheral kept the pin enable");

    a_unimpl_quiet: assert property (
        (pin_out & ~PIO_IMPL_MASK) == PIO_ZERO)
        else $error("unimplemented bit drives a level");

    a_reset_quiet: assert property (
        !$past(rst_n) |-> (output_latch_rd == PIO_LATCH_RESET && pin_out == PIO_ZERO))
        else $error("latch or pad data not cleared by reset");

    a_virt_reset: assert property (
        !$past(rst_n) |-> (virtual_pins == VIRT_RESET && !fault1_input && remap_in == 3'h0))
        else $error("virtual pins or remapper outputs not cleared by reset");

    c_periph_takeover: cover property (
        (own_now[0] == 1'b0 && direction_rd[0] == 1'b0) ##1 own_now[0] ##1 !pin_oe_n[0]);

    c_port_drives: cover property (
        output_latch_wr_en ##1 (pin_oe_n != PIO_OE_N_RESET));

    c_fault_from_cmp: cover property (
        (fault1_input_select == REMAP_SEL_CMP1 && comparator1_output) ##1 fault1_input);

    c_fault_from_virt: cover property (
        (fault1_input_select == REMAP_SEL_VIRT_BASE) ##2 fault1_input);

endmodule

// ==== logic/spio_pkg.sv ====
package spio_pkg;

    // ==========================================================
    // Port geometry
    localparam int PIO_W = 16;
    localparam logic [15:0] PIO_IMPL_MASK = 16'h3FFF;
    localparam logic [15:0] PIO_INPUT_ONLY_MASK = 16'h0300;

    // ==========================================================
    // Reset values
    localparam logic [15:0] PIO_DIR_RESET = 16'hFFFF;
    localparam logic [15:0] PIO_LATCH_RESET = 16'h0000;
    localparam logic [15:0] PIO_OE_N_RESET = 16'hFFFF;
    localparam logic [15:0] PIO_ZERO = 16'h0000;
    localparam logic [5:0] VIRT_RESET = 6'h00;

    // ==========================================================
    // Remapper select codes
    localparam int VIRT_N = 6;
    localparam int REMAP_SEL_W = 8;
    localparam int IN_REMAP_N = 4;
    localparam logic [7:0] REMAP_SEL_ZERO = 8'h00;
    localparam logic [7:0] REMAP_SEL_CMP1 = 8'h01;
    localparam logic [7:0] REMAP_SEL_PIN_BASE = 8'h20;
    localparam logic [7:0] REMAP_SEL_PIN_LAST = 8'h2F;
    localparam logic [7:0] REMAP_SEL_VIRT_BASE = 8'hB0;
    localparam logic [7:0] REMAP_SEL_VIRT_LAST = 8'hB5;

    // ==========================================================
    // State types
    typedef struct packed {
        logic [15:0] dir;
        logic [15:0] latch;
        logic [15:0] owned;
        logic [15:0] pin_out;
        logic [15:0] pin_oe_n;
        logic [15:0] dir_rd;
        logic [15:0] latch_rd;
        logic [15:0] pin_rd;
        logic [15:0] periph_in;
        logic [5:0] virt;
    } spio_state_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } spio_sync_t;

    typedef struct packed {
        logic out;
    } spio_remap_t;

endpackage

// ==== logic/spio_sync2.sv ====
`timescale 1ns/1ps
module spio_sync2
    import spio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);

    spio_sync_t st_ff;
    spio_sync_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.stage1 = d;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.stage2;

    // ==========================================================
    // Checks
    a_sync_latency: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($past(rst_n) && $past(rst_n, 2)) |-> (q == $past(d, 2)))
        else $error("synchroniser output is not input delayed by two");

endmodule

// ==== logic/spio_in_remap.sv ====
`timescale 1ns/1ps
module spio_in_remap
    import spio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] sel,
    input wire logic comparator1_output,
    input wire logic [15:0] pin_src,
    input wire logic [5:0] virt_src,
    output logic remap_out
);

    spio_remap_t st_ff;
    spio_remap_t nxt_st;
    logic [7:0] pin_off;
    logic [7:0] virt_off;

    always_comb
    begin
        nxt_st = st_ff;
        pin_off = sel - REMAP_SEL_PIN_BASE;
        virt_off = sel - REMAP_SEL_VIRT_BASE;
        if (sel == REMAP_SEL_CMP1)
        begin
            nxt_st.out = comparator1_output;
        end
        else if (sel >= REMAP_SEL_PIN_BASE && sel <= REMAP_SEL_PIN_LAST)
        begin
            nxt_st.out = pin_src[pin_off[3:0]];
        end
        else if (sel >= REMAP_SEL_VIRT_BASE && sel <= REMAP_SEL_VIRT_LAST)
        begin
            nxt_st.out = virt_src[virt_off[2:0]];
        end
        else
        begin
            // Unused codes read low so a stray select never floats a peripheral
            nxt_st.out = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign remap_out = st_ff.out;

    // ==========================================================
    // Checks
    a_virt_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sel >= REMAP_SEL_VIRT_BASE && sel <= REMAP_SEL_VIRT_LAST)
        |=> (remap_out == $past(virt_src[virt_off[2:0]])))
        else $error("virtual pin select returned the wrong source");

    a_fault_cmp_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sel == REMAP_SEL_CMP1) |=> (remap_out == $past(comparator1_output)))
        else $error("comparator select did not reach the remapper output");

    c_virt_used: cover property (@(posedge clk_sys) disable iff (!rst_n)
        (sel == REMAP_SEL_VIRT_LAST) ##1 remap_out);

endmodule

// ==== dv/spio_pad_model.sv ====
`timescale 1ns/1ps
module spio_pad_model
    import spio_pkg::*;
(
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    input wire logic [15:0] ext_level,
    output logic [15:0] pin_in
);
    // ==========================================================
    // Pad resolution
    // A pad the port leaves undriven follows the outside level, never a stale copy
    always_comb
    begin
        for (int i = 0; i < PIO_W; i++)
        begin
            pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
        end
    end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb
    import spio_pkg::*;
;
    logic clk_sys, rst_n, dir_we, lat_we, pv_we, cmp1, fault1_input;
    logic [15:0] wdata, pen, pdrv, pout, ext_level, pin_in, pin_out, pin_oe_n;
    logic [15:0] direction_rd, output_latch_rd, pin_value_rd, periph_in;
    logic [5:0] vro, virtual_pins;
    logic [7:0] f1sel;
    logic [23:0] rsel;
    logic [2:0] remap_in;
    int miscompares = 0;
    int compares = 0;

    spio_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .direction_wr_en(dir_we),
        .direction_wr_data(wdata), .output_latch_wr_en(lat_we),
        .output_latch_wr_data(wdata), .pin_value_wr_en(pv_we),
        .pin_value_wr_data(wdata), .direction_rd(direction_rd),
        .output_latch_rd(output_latch_rd), .pin_value_rd(pin_value_rd),
        .periph_enable(pen), .periph_drive(pdrv), .periph_out(pout),
        .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .virtual_remap_outputs(vro), .virtual_pins(virtual_pins),
        .comparator1_output(cmp1), .fault1_input_select(f1sel), .remap_select(rsel),
        .fault1_input(fault1_input), .remap_in(remap_in));

    spio_pad_model pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
        .pin_in(pin_in));

    // ==========================================================
    // Clock and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial
    begin
        #20000;
        miscompares++;
        print_verdict();
    end

    // ==========================================================
    // Access tasks
    // Inputs move 1 ns after the edge, so every sample sees settled values
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [2:0] en, input logic [15:0] d);
        {dir_we, lat_we, pv_we} = en;
        wdata = d;
        step(1);
        {dir_we, lat_we, pv_we} = 3'h0;
        // Let an edge pass so back-to-back calls never reassign a strobe in one step
        step(1);
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        rst_n = 1'b0;
        {dir_we, lat_we, pv_we, cmp1} = 4'h0;
        {wdata, pen, pdrv, pout} = 64'h0;
        ext_level = 16'h0000;
        vro = 6'h00;
        f1sel = 8'h00;
        rsel = 24'h00_0000;
        step(2);
        rst_n = 1'b1;
        chk("dir_reset", direction_rd, 16'h3FFF);
        chk("oe_reset", pin_oe_n, 16'hFFFF);
        chk("latch_reset", output_latch_rd, 16'h0000);
        $display("test reset done");

        wr(3'b010, 16'hFFFF);
        chk("latch_rd", output_latch_rd, 16'h3FFF);
        wr(3'b001, 16'h1234);
        chk("pv_write_latch", output_latch_rd, 16'h1234);
        $display("test latch done");

        wr(3'b100, 16'hFF00);
        chk("dir_rd", direction_rd, 16'h3F00);
        chk("dir_oe", pin_oe_n, 16'hFF00);
        chk("port_out", pin_out & 16'h00FF, 16'h0034);
        step(3);
        chk("pin_rd_low", pin_value_rd, 16'h0034);
        chk("loop_low", periph_in & 16'h3FFF, 16'h0000);
        ext_level = 16'hFFFF;
        step(3);
        chk("pin_rd_high", pin_value_rd, 16'h3F34);
        chk("loop_high", periph_in & 16'h3FFF, 16'h3F00);
        $display("test direction done");

        wr(3'b100, 16'hFFFF);
        pen = 16'hFFFF;
        pdrv = 16'hC30F;
        pout = 16'h000A;
        step(1);
        chk("own_oe", pin_oe_n, 16'hFFF0);
        chk("own_out", pin_out & 16'h000F, 16'h000A);
        step(3);
        chk("own_pin_rd", pin_value_rd, 16'h3FFA);
        pdrv = 16'h0000;
        wr(3'b100, 16'hFF00);
        step(1);
        chk("idle_oe", pin_oe_n, 16'hFF00);
        chk("idle_out", pin_out & 16'h00FF, 16'h0034);
        $display("test ownership done");

        for (int k = 0; k < VIRT_N; k++)
        begin
            vro = 6'h01 << k;
            f1sel = REMAP_SEL_VIRT_BASE + 8'(k);
            rsel = {3{REMAP_SEL_VIRT_BASE + 8'(k)}};
            step(1);
            chk("virt_pins", 16'(virtual_pins), 16'(vro));
            step(1);
            chk("virt_fault", 16'(fault1_input), 16'h0001);
            chk("virt_remap", 16'(remap_in), 16'h0007);
        end
        vro = 6'h00;
        f1sel = REMAP_SEL_CMP1;
        cmp1 = 1'b1;
        step(1);
        chk("cmp_fault_hi", 16'(fault1_input), 16'h0001);
        cmp1 = 1'b0;
        step(1);
        chk("cmp_fault_lo", 16'(fault1_input), 16'h0000);
        f1sel = REMAP_SEL_ZERO;
        cmp1 = 1'b1;
        rsel = {REMAP_SEL_PIN_LAST, REMAP_SEL_PIN_BASE + 8'h08, REMAP_SEL_PIN_BASE + 8'h02};
        step(1);
        chk("zero_sel", 16'(fault1_input), 16'h0000);
        chk("pin_remap", 16'(remap_in), 16'h0002);
        $display("test remap done");

        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        chk("dir_rereset", direction_rd, 16'h3FFF);
        chk("oe_rereset", pin_oe_n, 16'hFFFF);
        chk("out_rereset", pin_out, 16'h0000);
        step(3);
        chk("pin_rd_input", pin_value_rd, 16'h3FFF);
        $display("test second reset done");
        print_verdict();
    end
endmodule
